// file: src/config_prom_bitstream_output.v
// Configuration bitstream output path with serial and byte-wide modes
`timescale 1ns/1ps
`default_nettype none
`include "cfg_out_defines.vh"
// Operation
// - Serial bit on D0, advance per rising edge
// - Slave serial external clock, optional own clock
// - Slave byte clock from oscillator or device
// - Byte on D0-D7 when not busy, advance
// - Free-running clock allowed, busy pauses advance
// - Decompressor expands stored image before output
// - Revision chosen by pins or control bits
// - Chain devices via cascade enable output
// - Serial variant lacks byte-wide modes, own clock, decompressor and revision by control bits
// - Programming holds cascade enable high, others off
module config_prom_bitstream_output #(
  parameter PARALLEL_VARIANT = 1,
  parameter IMAGE_WORDS      = 4096
)(
  // System
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // Link pins
  input  wire        config_clock_i,
  input  wire        chip_select_n_i,
  input  wire        output_gate_i,
  input  wire        reconfig_request_n_i,
  input  wire        busy_i,
  input  wire [1:0]  mode_i,
  input  wire [1:0]  rev_sel_pins_i,
  input  wire        isp_active_i,
  // Control bits
  input  wire        rev_from_bits_i,
  input  wire [1:0]  rev_bits_i,
  input  wire        compress_en_i,
  input  wire        clock_drive_en_i,
  // Image load port
  input  wire        load_we_i,
  input  wire [11:0] load_addr_i,
  input  wire [7:0]  load_data_i,
  input  wire [11:0] image_end_i,
  // Outputs
  output reg  [7:0]  data_o,
  output reg  [7:0]  data_oe_o,
  output reg         config_clock_o,
  output reg         config_clock_oe_o,
  output reg         cascade_enable_out_o
);
  reg [7:0]  image [0:IMAGE_WORDS-1];
  reg [4:0]  s_config_clock;
  reg [1:0]  s_ce;
  reg [1:0]  s_oe;
  reg [1:0]  s_cf;
  reg [1:0]  s_busy;
  reg [1:0]  s_isp;
  reg [1:0]  s_mode_a;
  reg [1:0]  s_mode;
  reg [1:0]  s_rev_a;
  reg [1:0]  s_rev;
  reg        run_wait;
  reg [1:0]  state;
  reg [9:0]  addr;
  reg [7:0]  cur_byte;
  reg [2:0]  bit_idx;
  reg [7:0]  run_left;
  reg        run_pend;
  reg [3:0]  div_cnt;
  reg [7:0]  rd_byte;
  reg        active_d;
  wire [1:0] rev;
  wire       byte_mode;
  wire       own_clock;
  wire       rise;
  wire       selected;
  wire       active;
  wire       step;
  wire [11:0] rd_addr;
  integer    i;

  // Run-length token decode
  function is_token;
    input       en;
    input [7:0] b;
    begin
      is_token = en && (PARALLEL_VARIANT != 0) && (b == `TOKEN_RUN);
    end
  endfunction

  // serial-only variant falls back to serial modes
  assign byte_mode = (PARALLEL_VARIANT != 0) && s_mode[1];
  // revision select from pins or internal bits
  assign rev = (PARALLEL_VARIANT != 0 && rev_from_bits_i) ? rev_bits_i : s_rev;
  assign own_clock = (PARALLEL_VARIANT != 0) && !s_mode[1] ? (s_mode == `MODE_SLAVE_SERIAL) && clock_drive_en_i
                     : (s_mode == `MODE_SLAVE_BYTE) && clock_drive_en_i && (PARALLEL_VARIANT != 0);
  assign rise = own_clock ? (div_cnt == `CLK_DIV && !config_clock_o)
                          : (s_config_clock[3] && !s_config_clock[4]);
  assign selected = !s_ce[1] && s_oe[1] && s_cf[1] && !s_isp[1];
  assign active = selected && state != `ST_DONE;
  assign step = active && rise && !(byte_mode && s_busy[1]);
  assign rd_addr = {rev, addr};

  always @(posedge clk_sys_i)
  begin
    if (load_we_i)
    begin
      image[load_addr_i] <= load_data_i;
    end
    rd_byte <= image[rd_addr];
  end

  // Input synchronisers
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_config_clock <= 5'h00;
      s_ce   <= 2'h3;
      s_oe   <= 2'h0;
      s_cf   <= 2'h0;
      s_busy <= 2'h3;
      s_isp  <= 2'h0;
      s_mode_a <= 2'h0;
      s_mode   <= 2'h0;
      s_rev_a  <= 2'h0;
      s_rev    <= 2'h0;
    end
    else
    begin
      s_mode_a <= mode_i;
      s_mode   <= s_mode_a;
      s_rev_a  <= rev_sel_pins_i;
      s_rev    <= s_rev_a;
      s_config_clock <= {s_config_clock[3:0], config_clock_i};
      s_ce   <= {s_ce[0], chip_select_n_i};
      s_oe   <= {s_oe[0], output_gate_i};
      s_cf   <= {s_cf[0], reconfig_request_n_i};
      s_busy <= {s_busy[0], busy_i};
      s_isp  <= {s_isp[0], isp_active_i};
    end
  end

  // Own clock divider
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      div_cnt        <= 4'h0;
      config_clock_o <= 1'b0;
    end
    else if (!(active && state == `ST_RUN) && !config_clock_o)
    begin
      // Own clock parks low until data stands, so no edge precedes it
      div_cnt <= 4'h0;
    end
    else if (div_cnt == `CLK_DIV)
    begin
      div_cnt        <= 4'h0;
      config_clock_o <= !config_clock_o;
    end
    else
    begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // Read sequencer and run-length decompressor
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state    <= `ST_IDLE;
      addr     <= 10'h000;
      cur_byte <= 8'h00;
      bit_idx  <= 3'h7;
      run_left <= 8'h00;
      run_pend <= 1'b0;
      run_wait <= 1'b0;
      active_d <= 1'b0;
    end
    else
    begin
      active_d <= active;
      if (!s_cf[1])
      begin
        state    <= `ST_IDLE;
        addr     <= 10'h000;
        bit_idx  <= 3'h7;
        run_left <= 8'h00;
        run_pend <= 1'b0;
        run_wait <= 1'b0;
      end
      else
      begin
        case (state)
          `ST_IDLE:
          begin
            if (active && !active_d)
            begin
              cur_byte <= rd_byte;
              addr     <= addr + 10'h001;
              run_pend <= is_token(compress_en_i, rd_byte);
              state    <= `ST_RUN;
            end
          end
          `ST_RUN:
          begin
            if (step && (byte_mode || bit_idx == 3'h0))
            begin
              bit_idx <= 3'h7;
              // token 00 followed by count repeats zero bytes
              if (compress_en_i && PARALLEL_VARIANT != 0 && run_left != 8'h00)
              begin
                run_left <= run_left - 8'h01;
                cur_byte <= 8'h00;
              end
              else if ({2'h0, addr} > image_end_i[9:0] + 12'h000 && {rev, addr} > image_end_i)
              begin
                state <= `ST_DONE;
              end
              else
              begin
                cur_byte <= rd_byte;
                addr     <= addr + 10'h001;
                run_pend <= is_token(compress_en_i, rd_byte);
              end
            end
            else if (step)
            begin
              bit_idx <= bit_idx - 3'h1;
            end
            // Skip the count byte, then take it once its read has settled
            if (run_pend)
            begin
              run_pend <= 1'b0;
              run_wait <= 1'b1;
              addr     <= addr + 10'h001;
            end
            if (run_wait)
            begin
              run_wait <= 1'b0;
              run_left <= rd_byte;
            end
          end
          `ST_DONE:
          begin
            state <= `ST_DONE;
          end
          default:
          begin
            state <= `ST_IDLE;
          end
        endcase
      end
    end
  end

  // Output pins
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      data_o               <= 8'h00;
      data_oe_o            <= 8'h00;
      config_clock_oe_o    <= 1'b0;
      cascade_enable_out_o <= 1'b1;
    end
    else
    begin
      data_o[0] <= byte_mode ? cur_byte[0] : cur_byte[bit_idx];
      for (i = 1; i < 8; i = i + 1)
      begin
        data_o[i] <= byte_mode ? cur_byte[i] : 1'b0;
      end
      data_oe_o            <= (active && state == `ST_RUN) ? (byte_mode ? 8'hff : 8'h01) : 8'h00;
      config_clock_oe_o    <= own_clock && !s_isp[1];
      cascade_enable_out_o <= s_isp[1] || !(s_cf[1] && state == `ST_DONE) || s_ce[1];
    end
  end
endmodule // config_prom_bitstream_output
`default_nettype wire

// file: src/cfg_out_defines.vh
// Constants for the configuration bitstream output block
`ifndef CFG_OUT_DEFINES_VH
`define CFG_OUT_DEFINES_VH
`define MODE_MASTER_SERIAL 2'h0
`define MODE_SLAVE_SERIAL  2'h1
`define MODE_MASTER_BYTE   2'h2
`define MODE_SLAVE_BYTE    2'h3
`define ADDR_W             12
`define REV_W              2
`define REV_SHIFT          10
`define CLK_DIV            4'h7
`define TOKEN_RUN          8'h00
`define ST_IDLE            2'h0
`define ST_RUN             2'h1
`define ST_DONE            2'h2
`endif

// file: verif/config_prom_bitstream_output_props.sv
// Port checker for the configuration output block
`timescale 1ns/1ps
`default_nettype none
module cfg_out_props (
  input wire logic clk_sys_i, rst_i, config_clock_i, chip_select_n_i, output_gate_i,
  input wire logic reconfig_request_n_i, busy_i, isp_active_i, clock_drive_en_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] data_o, data_oe_o,
  input wire logic config_clock_o, config_clock_oe_o, cascade_enable_out_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire on = reconfig_request_n_i && !chip_select_n_i && output_gate_i && data_oe_o[0];
  a_isp_cascade: assert property (isp_active_i [*4] |-> cascade_enable_out_o) else $error("isp");
  a_desel_off: assert property ((chip_select_n_i || !output_gate_i) [*5] |-> !data_oe_o) else $error("desel");
  a_serial_one: assert property (!mode_i[1] [*4] |-> !data_oe_o[7:1]) else $error("serial");
  a_byte_all: assert property (mode_i[1] [*4] ##0 data_oe_o[0] |-> &data_oe_o) else $error("byte");
  a_busy_pause: assert property ((on && mode_i[1] && busy_i) [*6] |-> $stable(data_o)) else $error("busy");
  a_clock_quiet: assert property ((on && !clock_drive_en_i && !config_clock_i) [*8]
    |-> $stable(data_o)) else $error("idle");
  a_clk_off: assert property (!clock_drive_en_i [*4] |-> !config_clock_oe_o) else $error("drive");
  a_clk_half: assert property ($rose(config_clock_o) && config_clock_oe_o
    |=> config_clock_o [*7] ##1 !config_clock_o) else $error("period");
  c_busy: cover property (on && busy_i);
  c_own: cover property (on && config_clock_oe_o);
  c_done: cover property (!cascade_enable_out_o);
endmodule // cfg_out_props
bind config_prom_bitstream_output cfg_out_props i_props (.*);
`default_nettype wire

// file: verif/fpga_model.sv
// Far-side loader model capturing the bitstream
`timescale 1ns/1ps
`default_nettype none
module fpga_model (
  input wire logic run, ser, busy, config_clock,
  input wire logic [7:0] pin,
  output var logic fclk
);
  logic [7:0] got [16];
  logic [7:0] sr;
  int n = 0;
  int b = 0;
  initial fclk = 0;
  // Clock only inside frames
  always #32 fclk = run & ~fclk;
  // Capture on the edge after the advance, none while busy
  always @(posedge config_clock)
    if (run && !busy)
    begin
      sr = {sr[6:0], pin[0]};
      b = ser ? b + 1 : 8;
      if (b == 8)
      begin
        got[n] = ser ? sr : pin;
        n++;
        b = 0;
      end
    end
endmodule // fpga_model
`default_nettype wire

// file: verif/config_prom_bitstream_output_test.sv
// Testbench for the configuration output block
`timescale 1ns/1ps
`default_nettype none
module config_prom_bitstream_output_test;
  logic clk_sys_i = 0, rst_i = 1, chip_select_n_i = 1, output_gate_i = 1, reconfig_request_n_i = 1;
  logic busy_i = 0, isp_active_i = 0, rev_from_bits_i = 0, compress_en_i = 0, clock_drive_en_i = 0;
  logic load_we_i = 0, run = 0, fclk, config_clock_o, config_clock_oe_o, cascade_enable_out_o;
  logic [1:0] mode_i = 0, rev_sel_pins_i = 0, rev_bits_i = 0;
  logic [11:0] load_addr_i = 0, image_end_i = 12'h003;
  logic [7:0] load_data_i = 0, data_o, data_oe_o;
  logic [19:0] img [7] = '{20'h0005a, 20'h001c3, 20'h00281, 20'h0037e, 20'h40000, 20'h40102, 20'h402a5};
  int n_fail = 0, checked = 0;
  wire [7:0] pin = ~(data_o ^ data_oe_o);
  wire config_clock_i = config_clock_oe_o ? config_clock_o : fclk;
  always #2.5 clk_sys_i = ~clk_sys_i;
  config_prom_bitstream_output i_dut (.*);
  fpga_model i_fpga (.run, .ser(!mode_i[1]), .busy(busy_i), .config_clock(config_clock_i), .pin, .fclk);
  task automatic chk(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  // Release, reselect, optionally restart, run k units and compare
  task automatic frame(input logic [1:0] m, input bit rs, input int k, input logic [31:0] exp);
    chip_select_n_i = 1;
    output_gate_i = 0;
    tick(8);
    chk(data_oe_o, 8'h00);
    mode_i = m;
    output_gate_i = 1;
    chip_select_n_i = 0;
    reconfig_request_n_i = !rs;
    tick(8);
    reconfig_request_n_i = 1;
    tick(8);
    i_fpga.n = 0;
    run = 1;
    for (int t = 0; t < 3000 && i_fpga.n < k; t++) tick(1);
    run = 0;
    tick(20);
    chk(8'(i_fpga.n), 8'(k));
    for (int t = 0; t < k; t++) chk(i_fpga.got[t], exp[31 - 8 * t -: 8]);
  endtask
  // Byte-wide run to the image end
  task automatic t_byte;
    frame(2'h2, 1, 4, 32'h5ac3817e);
    chk({7'h00, cascade_enable_out_o}, 8'h00);
  endtask
  // Serial, released between bytes
  task automatic t_hold;
    frame(2'h0, 1, 1, 32'h5a000000);
    frame(2'h0, 0, 1, 32'hc3000000);
  endtask
  // Slave byte-wide with a busy pause
  task automatic t_busy;
    fork
      frame(2'h3, 1, 4, 32'h5ac3817e);
      begin
        @(negedge fclk);
        tick(1);
        busy_i = 1;
        tick(40);
        @(negedge fclk);
        tick(1);
        busy_i = 0;
      end
    join
  endtask
  // Revisions by bits and pins, expansion, own clock
  task automatic t_rev;
    rev_from_bits_i = 1;
    rev_bits_i = 2'h1;
    compress_en_i = 1;
    clock_drive_en_i = 1;
    image_end_i = 12'h402;
    frame(2'h1, 1, 4, 32'h000000a5);
    rev_from_bits_i = 0;
    rev_sel_pins_i = 2'h1;
    compress_en_i = 0;
    frame(2'h3, 1, 3, 32'h0002a500);
  endtask
  // Programming while selected and done
  task automatic t_isp;
    isp_active_i = 1;
    tick(8);
    chk({6'h00, cascade_enable_out_o, |{data_oe_o, config_clock_oe_o}}, 8'h02);
    isp_active_i = 0;
  endtask
  initial
  begin
    tick(20);
    rst_i = 0;
    load_we_i = 1;
    foreach (img[i])
    begin
      {load_addr_i, load_data_i} = img[i];
      tick(1);
    end
    load_we_i = 0;
    tick(4);
    t_byte;
    t_hold;
    t_busy;
    t_rev;
    t_isp;
    give_verdict;
  end
  initial
  begin
    #60us;
    n_fail++;
    give_verdict;
  end
endmodule // config_prom_bitstream_output_test
`default_nettype wire
